// ### verilog/lcfm_regs.svh
// Purpose: Named constants for the LED channel fault monitor.
// Assumes: 100 MHz mclk; AXI4-Lite byte addresses.
// Notes:   Definitions only; included by bare name.
`ifndef LCFM_REGS_SVH
`define LCFM_REGS_SVH

// ***************************************************************
// Structure
// ***************************************************************
`define LCFM_NCH 4
`define LCFM_SYNC_W 33
`define LCFM_CNT_W 16
`define LCFM_ADDR_W 8
`define LCFM_DATA_W 32
`define LCFM_STAT_PAD 21
`define LCFM_CTRL_PAD 28

// ***************************************************************
// Timing
// ***************************************************************
`define LCFM_CLK_PERIOD_NS 10
`define LCFM_GS_DEG_NS 125000
`define LCFM_OPEN_DEG_NS 125000

// ***************************************************************
// Register map and reset values
// ***************************************************************
`define LCFM_CTRL_OFS 8'h00
`define LCFM_STAT_OFS 8'h04
`define LCFM_CTRL_RST 4'hf
`define LCFM_RESP_OKAY 2'h0
`define LCFM_RESP_SLVERR 2'h2

`endif

// ### verilog/lcfm_pkg.sv
// Purpose: Shared types for the LED channel fault monitor.
// Assumes: Constants come from lcfm_regs.svh.
// Notes:   Types only.
package lcfm_pkg;
  // Per-channel fault state
  typedef enum logic [1:0] {ch_run, ch_gnd, ch_open} lcfm_ch_state_type;
endpackage : lcfm_pkg

// ### verilog/lcfm_sync.sv
// Purpose: Two-flop synchroniser for all asynchronous comparator pins.
// Assumes: Inputs change slowly against mclk.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/1ps
`include "lcfm_regs.svh"
module lcfm_sync import lcfm_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Data
  input wire logic [`LCFM_SYNC_W-1:0] async_in,
  output logic [`LCFM_SYNC_W-1:0] sync_out
);
  typedef struct packed {
    logic [`LCFM_SYNC_W-1:0] meta; // First stage, read by stage two only
    logic [`LCFM_SYNC_W-1:0] stab; // Second stage
  } lcfm_sync_state_type;

  lcfm_sync_state_type st_q, st_d;

  // Shift chain
  always_comb begin
    st_d = st_q;
    st_d.meta = async_in;
    st_d.stab = st_q.meta;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.stab;
endmodule : lcfm_sync

// ### verilog/lcfm_deglitch.sv
// Purpose: Deglitch timer with hysteresis restart.
// Assumes: trip and clear come from synchronised comparators.
// Notes:   Between thresholds the count keeps running once started.
`timescale 1ns/1ps
`include "lcfm_regs.svh"
module lcfm_deglitch import lcfm_pkg::*; (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Control
  input wire logic arm,
  input wire logic trip,
  input wire logic clear,
  input wire logic [`LCFM_CNT_W-1:0] limit,
  // Result
  output logic done
);
  typedef struct packed {
    logic [`LCFM_CNT_W-1:0] cnt; // Cycles spent in the fault window
  } lcfm_dg_state_type;

  lcfm_dg_state_type st_q, st_d;

  // Count while tripped; restart on disarm or on return above the high threshold
  always_comb begin
    st_d = st_q;
    if (!arm || clear) begin
      st_d.cnt = '0;
    end else if ((trip || st_q.cnt != '0) && st_q.cnt != limit) begin
      st_d.cnt = st_q.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign done = arm && (st_q.cnt == limit);

  // ***************************************************************
  // Assertions
  // ***************************************************************
  a_clear_restart: assert property (@(posedge mclk) disable iff (rst)
    (arm && clear) |=> (st_q.cnt == '0))
    else $error("deglitch count not restarted by clear");
  a_done_needs_time: assert property (@(posedge mclk) disable iff (rst)
    $rose(done) |-> $past(arm, 1) && ($past(st_q.cnt) == limit - 1'b1))
    else $error("deglitch finished without full interval");
endmodule : lcfm_deglitch

// ### verilog/lcfm_top.sv
// Purpose: Four-channel LED fault monitor and fault bus control.
// Assumes: Comparator pins are asynchronous; mclk is 100 MHz.
// Notes:   Registers over AXI4-Lite; fault bus is open drain.
//
// Overview of operation
// - Supply below reset level kills all outputs; here the weak pullup stays on
// - Regulate only with dim high, unforced
// - Ground-short monitor only while output enabled
// - Deglitched ground short latches, pulls bus
// - Both outputs recover: restart ground timer
// - Ground fault: stop regulation, retry always
// - Retry sees recovery: clear, resume regulation
// - Open monitor needs detect enable and dim
// - Short to battery counts as open
// - Deglitched open condition latches, pulls bus
// - Difference recovers: restart open timer
// - Open fault: stop regulation, gated retry
// - Open gone: resume, release bus
// - Detect enable gates open detection only
// - Overtemperature: all off, bus held low
// - Weak pullup idle, strong pulldown on fault
// - Bus sensed low turns outputs off
// - Stay off until bus above high level
// - Ground deglitch nominal 125 microseconds
// - Dim low disables output and diagnostics
//
// Chosen here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "lcfm_regs.svh"
module lcfm_top import lcfm_pkg::*; #(
  // Deglitch counts in mclk cycles, shortened in simulation
  parameter logic [`LCFM_CNT_W-1:0] GS_DEG_CYC =
    `LCFM_CNT_W'(`LCFM_GS_DEG_NS / `LCFM_CLK_PERIOD_NS),
  parameter logic [`LCFM_CNT_W-1:0] OPEN_DEG_CYC =
    `LCFM_CNT_W'(`LCFM_OPEN_DEG_NS / `LCFM_CLK_PERIOD_NS)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // AXI4-Lite write channels
  input wire logic [`LCFM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`LCFM_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [`LCFM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [`LCFM_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Control pins
  input wire logic [`LCFM_NCH-1:0] channel_dim_input,
  input wire logic open_detect_enable,
  input wire logic supply_below_por,
  input wire logic overtemp_flag,
  // Per-channel comparators
  input wire logic [`LCFM_NCH-1:0] direct_below_gs_low,
  input wire logic [`LCFM_NCH-1:0] resistor_below_gs_low,
  input wire logic [`LCFM_NCH-1:0] direct_above_gs_high,
  input wire logic [`LCFM_NCH-1:0] resistor_above_gs_high,
  input wire logic [`LCFM_NCH-1:0] diff_below_open_low,
  input wire logic [`LCFM_NCH-1:0] diff_above_open_high,
  // Fault bus sense comparators
  input wire logic fault_bus_below_low,
  input wire logic fault_bus_above_high,
  // Channel drive
  output logic [`LCFM_NCH-1:0] regulate_en,
  output logic [`LCFM_NCH-1:0] retry_en,
  // Fault bus open drain
  output logic fault_bus_out,
  output logic fault_bus_oe,
  output logic fault_bus_weak_pullup
);
  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    lcfm_ch_state_type [`LCFM_NCH-1:0] st; // Channel fault state
    logic ext_hold;                          // Bus seen low, not yet high
    logic [`LCFM_NCH-1:0] mask;              // Software channel enable
    logic [`LCFM_NCH-1:0] reg_en;            // Regulation enables
    logic [`LCFM_NCH-1:0] retry;             // Retry current enables
    logic pull_oe;                           // Strong pulldown
    logic weak_pu;                           // Weak pullup
    logic bus_out;                           // Open drain data, always low
    logic aw_have;                           // Write address held
    logic w_have;                            // Write data held
    logic [`LCFM_ADDR_W-1:0] awaddr;
    logic [`LCFM_NCH-1:0] wmask;
    logic wlane0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [`LCFM_DATA_W-1:0] rdata;
  } lcfm_top_state_type;

  lcfm_top_state_type st_q, st_d;

  // Synchronised pins
  logic [`LCFM_NCH-1:0] dim_s, dlo_s, rlo_s, dhi_s, rhi_s, olo_s, ohi_s;
  logic ode_s, por_s, ot_s, blo_s, bhi_s;
  logic [`LCFM_NCH-1:0] dim_m;   // Dim gated by software mask
  logic [`LCFM_NCH-1:0] gs_arm, gs_done, op_arm, op_done;

  // Channel is running normally
  function automatic logic is_run(input lcfm_ch_state_type s);
    is_run = (s == ch_run);
  endfunction : is_run

  // Vector of channels in a given fault state
  function automatic logic [`LCFM_NCH-1:0] in_state(
    input lcfm_ch_state_type [`LCFM_NCH-1:0] s, input lcfm_ch_state_type w);
    for (int i = 0; i < `LCFM_NCH; i++) begin
      in_state[i] = (s[i] == w);
    end
  endfunction : in_state

  // ***************************************************************
  // Pin synchronisation and deglitch timers
  // ***************************************************************
  lcfm_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({channel_dim_input, direct_below_gs_low, resistor_below_gs_low,
               direct_above_gs_high, resistor_above_gs_high, diff_below_open_low,
               diff_above_open_high, open_detect_enable, supply_below_por,
               overtemp_flag, fault_bus_below_low, fault_bus_above_high}),
    .sync_out({dim_s, dlo_s, rlo_s, dhi_s, rhi_s, olo_s, ohi_s,
               ode_s, por_s, ot_s, blo_s, bhi_s})
  );

  assign dim_m = dim_s & st_q.mask;

  for (genvar g = 0; g < `LCFM_NCH; g++) begin : g_ch
    // Ground-short timer runs only on an enabled, healthy channel
    assign gs_arm[g] = is_run(st_q.st[g]) && st_q.reg_en[g];
    // Open timer also needs detect enable and dim; high output counts too
    assign op_arm[g] = gs_arm[g] && ode_s && dim_m[g];

    lcfm_deglitch u_gs (
      .mclk(mclk),
      .rst(rst),
      .arm(gs_arm[g]),
      .trip(dlo_s[g] | rlo_s[g]),
      .clear(dhi_s[g] & rhi_s[g]),
      .limit(GS_DEG_CYC),
      .done(gs_done[g])
    );

    lcfm_deglitch u_op (
      .mclk(mclk),
      .rst(rst),
      .arm(op_arm[g]),
      .trip(olo_s[g]),
      .clear(ohi_s[g]),
      .limit(OPEN_DEG_CYC),
      .done(op_done[g])
    );
  end

  // ***************************************************************
  // Fault handling and bus slave
  // ***************************************************************
  // Next-state logic; all outputs are registered from st_d
  always_comb begin
    logic off_all;
    logic any_fault;
    off_all = 1'b0;
    any_fault = 1'b0;
    st_d = st_q;
    // Bus low latches until it climbs above the high level
    st_d.ext_hold = blo_s | (st_q.ext_hold & ~bhi_s);
    off_all = por_s | ot_s | blo_s | st_d.ext_hold;
    for (int i = 0; i < `LCFM_NCH; i++) begin
      case (st_q.st[i])
        // Latch the first deglitched fault; ground wins a tie
        ch_run: begin
          if (gs_done[i]) begin
            st_d.st[i] = ch_gnd;
          end else if (op_done[i]) begin
            st_d.st[i] = ch_open;
          end
        end
        // Retry pulls the output up; both nodes high ends the fault
        ch_gnd: begin
          if (dhi_s[i] && rhi_s[i]) begin
            st_d.st[i] = ch_run;
          end
        end
        // Condition gone once the difference is no longer low
        ch_open: begin
          if (!olo_s[i]) begin
            st_d.st[i] = ch_run;
          end
        end
        default: begin
          st_d.st[i] = ch_run;
        end
      endcase
      // Supply reset clears every channel's fault latch
      if (por_s) begin
        st_d.st[i] = ch_run;
      end
      st_d.reg_en[i] = is_run(st_d.st[i]) && dim_m[i] && !off_all;
      // Retry ignores dim; open retry only with detect enable
      st_d.retry[i] = !por_s && !ot_s && ((st_d.st[i] == ch_gnd) ||
                      ((st_d.st[i] == ch_open) && ode_s));
      any_fault = any_fault | !is_run(st_d.st[i]);
    end
    st_d.pull_oe = !por_s && (ot_s || any_fault);
    st_d.weak_pu = !st_d.pull_oe;
    st_d.bus_out = 1'b0;

    // Write response taken: free both holding slots
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
    end
    // Address and data may arrive in either order
    if (s_axi_awvalid && st_q.awready) begin
      st_d.aw_have = 1'b1;
      st_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_q.wready) begin
      st_d.w_have = 1'b1;
      st_d.wmask = s_axi_wdata[`LCFM_NCH-1:0];
      st_d.wlane0 = s_axi_wstrb[0];
    end
    // Perform the write once both halves are held
    if (st_d.aw_have && st_d.w_have && !st_d.bvalid) begin
      st_d.bvalid = 1'b1;
      st_d.bresp = `LCFM_RESP_OKAY;
      if (st_d.awaddr == `LCFM_CTRL_OFS) begin
        if (st_d.wlane0) begin
          st_d.mask = st_d.wmask;
        end
      end else if (st_d.awaddr != `LCFM_STAT_OFS) begin
        st_d.bresp = `LCFM_RESP_SLVERR;
      end
    end
    st_d.awready = !st_d.aw_have;
    st_d.wready = !st_d.w_have;

    // Read: one outstanding, data captured at the address handshake
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = `LCFM_RESP_OKAY;
      if (s_axi_araddr == `LCFM_CTRL_OFS) begin
        st_d.rdata = {{`LCFM_CTRL_PAD{1'b0}}, st_q.mask};
      end else if (s_axi_araddr == `LCFM_STAT_OFS) begin
        st_d.rdata = {{`LCFM_STAT_PAD{1'b0}}, por_s, ot_s, st_q.ext_hold,
                      in_state(st_q.st, ch_open), in_state(st_q.st, ch_gnd)};
      end else begin
        st_d.rdata = '0;
        st_d.rresp = `LCFM_RESP_SLVERR;
      end
    end
    st_d.arready = !st_d.rvalid;
  end

  // State register; reset clears all latches and sets the channel mask
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_q <= '0;
      st_q.mask <= `LCFM_CTRL_RST;
      st_q.weak_pu <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from the state register
  assign regulate_en = st_q.reg_en;
  assign retry_en = st_q.retry;
  assign fault_bus_out = st_q.bus_out;
  assign fault_bus_oe = st_q.pull_oe;
  assign fault_bus_weak_pullup = st_q.weak_pu;
  assign s_axi_awready = st_q.awready;
  assign s_axi_wready = st_q.wready;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_arready = st_q.arready;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rresp = st_q.rresp;
  assign s_axi_rdata = st_q.rdata;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  a_por_all_off: assert property (@(posedge mclk) disable iff (rst)
    por_s |=> (regulate_en == '0) && (retry_en == '0) && !fault_bus_oe)
    else $error("outputs active under supply reset");
  a_reg_needs_dim: assert property (@(posedge mclk) disable iff (rst)
    ((regulate_en & ~$past(dim_m)) == '0))
    else $error("regulation without dim input");
  a_gnd_from_enabled: assert property (@(posedge mclk) disable iff (rst)
    (in_state(st_d.st, ch_gnd) & ~in_state(st_q.st, ch_gnd) & ~st_q.reg_en) == '0)
    else $error("ground fault on disabled channel");
  a_fault_pulls_bus: assert property (@(posedge mclk) disable iff (rst)
    (~in_state(st_d.st, ch_run) != '0) && !por_s |=> fault_bus_oe && !fault_bus_weak_pullup)
    else $error("fault present but bus not pulled");
  a_gnd_retry_on: assert property (@(posedge mclk) disable iff (rst)
    ((in_state(st_q.st, ch_gnd) & (~retry_en | regulate_en)) == '0) || $past(por_s | ot_s))
    else $error("ground fault channel not in retry");
  a_gnd_recover: assert property (@(posedge mclk) disable iff (rst)
    (st_q.st[0] == ch_gnd) && dhi_s[0] && rhi_s[0] |=> is_run(st_q.st[0]))
    else $error("ground fault not cleared on recovery");
  a_open_gated: assert property (@(posedge mclk) disable iff (rst)
    (st_q.st[0] == ch_run) ##1 (st_q.st[0] == ch_open) |-> $past(ode_s, 2) && $past(dim_m[0], 2))
    else $error("open fault without detect enable and dim");
  a_ot_off: assert property (@(posedge mclk) disable iff (rst)
    ot_s && !por_s |=> (regulate_en == '0) && (retry_en == '0) && fault_bus_oe)
    else $error("overtemperature did not shut down");
  a_bus_hold: assert property (@(posedge mclk) disable iff (rst)
    st_q.ext_hold && !bhi_s |=> st_q.ext_hold && (regulate_en == '0))
    else $error("outputs resumed before bus high");
  a_bus_low_off: assert property (@(posedge mclk) disable iff (rst)
    blo_s |=> (regulate_en == '0))
    else $error("regulation while bus low");
endmodule : lcfm_top

// ### tb/lcfm_bus_peer.sv
// Purpose: Shared fault bus with the other drivers tied to it.
// Assumes: The bus comparators see the wire level and nothing else.
// Notes:   Any pulldown wins over every weak pullup on the wire.
`timescale 1ns/1ps
module lcfm_bus_peer (
  // Our device's drive
  input wire logic fault_bus_oe,
  input wire logic fault_bus_weak_pullup,
  // Another driver pulling the bus low
  input wire logic peer_pull,
  // Sensed level
  output logic fault_bus_below_low,
  output logic fault_bus_above_high
);
  // Wire level; peers keep their weak pullups on while idle
  logic bus_high;
  // Strong pulldowns beat pullups; peers alone keep the bus up
  assign bus_high = !(fault_bus_oe || peer_pull);
  // Both comparators follow the wire, so a release reads high at once
  assign fault_bus_below_low = !bus_high;
  assign fault_bus_above_high = bus_high;
endmodule : lcfm_bus_peer

// ### tb/lcfm_top_tb_top.sv
// Purpose: Directed checks of the fault monitor through pins and registers.
// Assumes: Deglitch counts cut to 8 cycles; latency 3 edges per pin change.
// Notes:   Waits after pin changes exceed the stated latencies.
`timescale 1ns/1ps
`include "lcfm_regs.svh"
module lcfm_top_tb_top;
  // ********
  // Signals
  // ********
  logic mclk, rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, dim, dbl, rbl, dah, rah, dbo, dao, regulate_en, retry_en;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic ode, por, ot, peer_pull, bus_lo, bus_hi, fb_out, fb_oe, fb_weak;
  int failures, compares;
  // Design under test with short deglitch counts
  lcfm_top #(.GS_DEG_CYC(16'h0008), .OPEN_DEG_CYC(16'h0008)) uut (
    .mclk(mclk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .channel_dim_input(dim), .open_detect_enable(ode), .supply_below_por(por),
    .overtemp_flag(ot), .direct_below_gs_low(dbl), .resistor_below_gs_low(rbl),
    .direct_above_gs_high(dah), .resistor_above_gs_high(rah),
    .diff_below_open_low(dbo), .diff_above_open_high(dao),
    .fault_bus_below_low(bus_lo), .fault_bus_above_high(bus_hi),
    .regulate_en(regulate_en), .retry_en(retry_en), .fault_bus_out(fb_out),
    .fault_bus_oe(fb_oe), .fault_bus_weak_pullup(fb_weak));
  // The other drivers on the bus
  lcfm_bus_peer peer (.fault_bus_oe(fb_oe), .fault_bus_weak_pullup(fb_weak),
    .peer_pull(peer_pull), .fault_bus_below_low(bus_lo), .fault_bus_above_high(bus_hi));
  // 100 MHz clock
  always #5 mclk = ~mclk;
  // ********
  // Tasks
  // ********
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Wait whole cycles
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask : wt
  // Wait whole cycles, checking at every edge that the pulldown stays off
  task automatic wt_quiet(input string nm, input int n);
    repeat (n) begin
      @(posedge mclk);
      chk(nm, fb_oe, 32'h0);
    end
  endtask : wt_quiet
  // AXI4-Lite write; both channels offered together, each released when taken
  task automatic wrc(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge mclk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
    @(posedge mclk);
  endtask : wrc
  // AXI4-Lite read with expected data and response
  task automatic rdc(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge mclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, ed);
    chk("rresp", s_axi_rresp, er);
    @(posedge mclk);
  endtask : rdc
  // Counts and verdict
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test
  // ********
  // Watchdog
  // ********
  // Tests take under 2000 cycles; a hang ends the run as a mismatch
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    finish_test();
  end
  // ********
  // Tests
  // ********
  initial begin
    {mclk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h08;
    {s_axi_arvalid, s_axi_rready, ode, por, ot, peer_pull} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {dim, dbl, rbl, dbo} = 16'h0000;
    {dah, rah, dao} = 12'hfff;
    failures = 0;
    compares = 0;
    wt(20);
    rst <= 1'b0;
    wt(3);
    chk("reg_rst", regulate_en, 32'h0);
    chk("weak_rst", fb_weak, 32'h1);
    rdc(`LCFM_CTRL_OFS, 32'h0000000f, `LCFM_RESP_OKAY);
    rdc(`LCFM_STAT_OFS, 32'h0, `LCFM_RESP_OKAY);
    dim <= 4'hf;
    wt(10);
    chk("reg_on", regulate_en, 32'hf);
    $display("test reset done");
    // Register access, mask and unmapped address
    wrc(`LCFM_CTRL_OFS, 32'h00000003, `LCFM_RESP_OKAY);
    wt(5);
    chk("reg_mask", regulate_en, 32'h3);
    rdc(8'h08, 32'h0, `LCFM_RESP_SLVERR);
    wrc(8'h08, 32'h0, `LCFM_RESP_SLVERR);
    wrc(`LCFM_CTRL_OFS, 32'h0000000f, `LCFM_RESP_OKAY);
    dim <= 4'hd;
    wt(10);
    chk("reg_dim", regulate_en, 32'hd);
    dim <= 4'hf;
    $display("test registers done");
    // Two short dips; each recovery restarts the ground timer
    repeat (2) begin
      dbl <= 4'h1;
      dah <= 4'he;
      wt_quiet("oe_glitch", 6);
      dbl <= 4'h0;
      dah <= 4'hf;
      wt_quiet("oe_glitch", 2);
    end
    wt_quiet("oe_glitch", 20);
    chk("oe_glitch", fb_oe, 32'h0);
    // Resistor path short on channel 0
    rbl <= 4'h1;
    rah <= 4'he;
    wt(30);
    chk("retry_gs", retry_en, 32'h1);
    chk("oe_gs", fb_oe, 32'h1);
    chk("weak_gs", fb_weak, 32'h0);
    chk("out_gs", fb_out, 32'h0);
    chk("reg_gs", regulate_en, 32'h0);
    rdc(`LCFM_STAT_OFS, 32'h00000101, `LCFM_RESP_OKAY);
    dim <= 4'he;
    wt(10);
    chk("retry_dim", retry_en, 32'h1);
    rbl <= 4'h0;
    rah <= 4'hf;
    wt(20);
    chk("retry_clr", retry_en, 32'h0);
    chk("oe_clr", fb_oe, 32'h0);
    chk("reg_back", regulate_en, 32'he);
    // Short on a channel that is off is not monitored; only the direct node held low
    dbl <= 4'h1;
    dah <= 4'he;
    wt(30);
    chk("oe_off", fb_oe, 32'h0);
    dbl <= 4'h0;
    dah <= 4'hf;
    dim <= 4'hf;
    $display("test ground short done");
    // Open or short to battery on channel 2, first with detection off
    dbo <= 4'h4;
    dao <= 4'hb;
    wt(30);
    chk("oe_nodet", fb_oe, 32'h0);
    ode <= 1'b1;
    wt(30);
    chk("oe_open", fb_oe, 32'h1);
    chk("retry_open", retry_en, 32'h4);
    chk("reg_open", regulate_en, 32'h0);
    rdc(`LCFM_STAT_OFS, 32'h00000140, `LCFM_RESP_OKAY);
    dbo <= 4'h0;
    dao <= 4'hf;
    wt(20);
    chk("oe_open_clr", fb_oe, 32'h0);
    chk("reg_open_clr", regulate_en, 32'hf);
    // Two short open dips; each recovery restarts the open timer
    repeat (2) begin
      dbo <= 4'h4;
      dao <= 4'hb;
      wt_quiet("oe_open_glitch", 6);
      dbo <= 4'h0;
      dao <= 4'hf;
      wt_quiet("oe_open_glitch", 2);
    end
    wt_quiet("oe_open_glitch", 20);
    ode <= 1'b0; // Held low as a low dropout system would
    $display("test open done");
    // Overtemperature
    ot <= 1'b1;
    wt(10);
    chk("reg_ot", regulate_en, 32'h0);
    chk("oe_ot", fb_oe, 32'h1);
    ot <= 1'b0;
    wt(20);
    chk("reg_ot_clr", regulate_en, 32'hf);
    // Another driver pulls the bus
    peer_pull <= 1'b1;
    wt(30);
    chk("reg_ext", regulate_en, 32'h0);
    chk("oe_ext", fb_oe, 32'h0);
    peer_pull <= 1'b0;
    wt(10);
    chk("reg_ext_clr", regulate_en, 32'hf);
    // Supply under reset level, with a ground fault latched on channel 1
    dbl <= 4'h2;
    dah <= 4'hd;
    wt(30);
    chk("oe_gs1", fb_oe, 32'h1);
    por <= 1'b1;
    wt(10);
    chk("reg_por", regulate_en, 32'h0);
    chk("oe_por", fb_oe, 32'h0);
    chk("retry_por", retry_en, 32'h0);
    rdc(`LCFM_STAT_OFS, 32'h00000400, `LCFM_RESP_OKAY);
    dbl <= 4'h0;
    dah <= 4'hf;
    por <= 1'b0;
    wt(10);
    chk("reg_por_clr", regulate_en, 32'hf);
    $display("test protection done");
    finish_test();
  end
endmodule : lcfm_top_tb_top
